// ==== verif/host_model.sv ====
// Remote host model that issues status commands one cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import status_report_pkg::*;
(
  input  wire logic      clk,
  output var  host_req_s req
);
  initial req = '0;
  // Holds one command for a single edge, then releases it.
  task automatic send(input host_cmd_e cmd, input logic [7:0] data);
    @(posedge clk);
    req <= '{valid: 1'b1, cmd: cmd, data: data};
    @(posedge clk);
    req <= '0;
  endtask : send
  // Holds two commands on consecutive edges, then releases them.
  task automatic send_pair(input host_cmd_e cmd_a, input logic [7:0] data_a,
                           input host_cmd_e cmd_b, input logic [7:0] data_b);
    @(posedge clk);
    req <= '{valid: 1'b1, cmd: cmd_a, data: data_a};
    @(posedge clk);
    req <= '{valid: 1'b1, cmd: cmd_b, data: data_b};
    @(posedge clk);
    req <= '0;
  endtask : send_pair
endmodule : host_model
`default_nettype wire

// ==== verif/status_report_test.sv ====
// Self-checking testbench for the status reporting block.
`timescale 1ns/1ps
`default_nettype none
module status_report_test;
  import status_report_pkg::*;
  typedef struct {host_cmd_e cmd; logic [7:0] data; logic [7:0] exp;} row_s;
  logic clk = 1'b0, resetn = 1'b0, op_done = 1'b0, err_valid = 1'b0;
  logic out_msg_waiting = 1'b0, err_pop = 1'b0, rsp_valid, srq, err_empty;
  err_kind_e err_kind = EKIND_CMD_GENERIC;
  host_req_s req;
  logic [7:0] rsp_data, status_byte;
  logic signed [15:0] err_head;
  int errors = 0, checked = 0;
  row_s rows[6] = '{'{CMD_RD_EVT, 8'h00, 8'h80}, '{CMD_RD_EVT, 8'h00, 8'h00},
    '{CMD_WR_EEN, 8'h01, 8'h00}, '{CMD_RD_EEN, 8'h00, 8'h01},
    '{CMD_WR_SRE, 8'h20, 8'h00}, '{CMD_RD_SRE, 8'h00, 8'h20}};
  logic [15:0] num[6] = '{16'hff9c, 16'hff9a, 16'hff94, 16'hff22, 16'hfe70, 16'hfea2};
  logic [7:0] grp[6] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h04, 8'h08};
  always #4 clk = ~clk;
  host_model h (.clk(clk), .req(req));
  status_report #(.QUEUE_DEPTH(2)) i_dut (.clk(clk), .resetn(resetn), .req(req),
    .op_done(op_done), .err_valid(err_valid), .err_kind(err_kind),
    .out_msg_waiting(out_msg_waiting), .err_pop(err_pop), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .srq(srq), .status_byte(status_byte), .err_head(err_head),
    .err_empty(err_empty));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic rd(input host_cmd_e c, input logic [7:0] e);
    int i;
    h.send(c, 8'h00);
    for (i = 0; i < 3; i++) begin
      #1;
      if (rsp_valid === 1'b1) break;
      @(posedge clk);
    end
    chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
    chk("rsp_data", {8'h00, rsp_data}, {8'h00, e});
  endtask : rd
  task automatic err(input int k);
    @(posedge clk);
    err_valid <= 1'b1;
    err_kind <= err_kind_e'(k);
    @(posedge clk);
    err_valid <= 1'b0;
  endtask : err
  task automatic pop();
    @(posedge clk);
    err_pop <= 1'b1;
    @(posedge clk);
    err_pop <= 1'b0;
    tick(3);
  endtask : pop
  task automatic give_verdict();
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[r]) begin
      if (rows[r].cmd inside {CMD_WR_EEN, CMD_WR_SRE}) h.send(rows[r].cmd, rows[r].data);
      else rd(rows[r].cmd, rows[r].exp);
    end
    @(posedge clk);
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    tick(3);
    chk("status_byte", {8'h00, status_byte}, 16'h0060);
    chk("srq", {15'h0000, srq}, 16'h0001);
    rd(CMD_RD_STB, 8'h60);
    rd(CMD_RD_STB, 8'h60);
    @(posedge clk);
    out_msg_waiting <= 1'b1;
    tick(3);
    chk("status_byte", {8'h00, status_byte}, 16'h0070);
    h.send(CMD_WR_SRE, 8'h00);
    tick(3);
    chk("status_byte", {8'h00, status_byte}, 16'h0030);
    chk("srq", {15'h0000, srq}, 16'h0000);
    @(posedge clk);
    out_msg_waiting <= 1'b0;
    err(0);
    h.send(CMD_CLEAR, 8'h00);
    tick(3);
    chk("status_byte", {8'h00, status_byte}, 16'h0000);
    chk("err_empty", {15'h0000, err_empty}, 16'h0001);
    for (int k = 0; k < 6; k++) begin
      err(k);
      tick(3);
      chk("err_head", err_head, num[k]);
      rd(CMD_RD_EVT, grp[k]);
      pop();
      chk("err_empty", {15'h0000, err_empty}, 16'h0001);
    end
    for (int k = 0; k < 3; k++) err(k);
    tick(3);
    chk("err_head", err_head, 16'hff9c);
    pop();
    chk("err_head", err_head, 16'hfea2);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(CMD_RD_EVT, 8'h80);
    h.send(CMD_WR_EEN, 8'h20);
    h.send_pair(CMD_WR_SRE, 8'h20, CMD_RD_SRE, 8'h00);
    #1;
    chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
    chk("rsp_data", {8'h00, rsp_data}, 16'h0020);
    err(0);
    tick(3);
    chk("status_byte", {8'h00, status_byte}, 16'h0060);
    rd(CMD_RD_EVT, 8'h20);
    tick(3);
    chk("status_byte", {8'h00, status_byte}, 16'h0000);
    chk("srq", {15'h0000, srq}, 16'h0000);
    give_verdict();
  end
endmodule : status_report_test
`default_nettype wire

// ==== verilog/status_report.sv ====
// Status byte, event status and error queue logic for the remote host interface.
// Functional notes
// RULE1: Reading event status returns its value then clears all its bits.
// RULE2: Event enable bits line up one to one with event status bits.
// RULE3: Power-on bit 7 is set by every reset of the unit.
// RULE4: Recorded errors set the event bit of their code group.
// RULE5: Enabled event bits are ORed into status byte bit 5.
// RULE6: Reading the status byte clears nothing.
// RULE7: Message-available clears at power-on and on clear-status.
// RULE8: Status byte holds bits 4, 5, 6 only; other bits read zero.
// RULE9: Master summary bit 6 is OR of status byte ANDed with enables.
// RULE10: Zero service request enable never raises a service request.
// RULE11: A full error queue drops new errors and records queue overflow.
// RULE12: Error kinds map to numbers -100, -102, -108, -222, -400.
// RULE13: Clear-status empties event status, status byte and error queue.
// RULE14: Message-available follows a waiting output message.
// RULE15: Master summary is unlatched and follows its masked OR.
// RULE16: Enable registers read back exactly the last written value.
// RULE17: Event bits stay set until read or clear-status.
`timescale 1ns/1ps
`default_nettype none
`include "status_report_defines.svh"
module status_report
  import status_report_pkg::*;
#(
  parameter int QUEUE_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire host_req_s   req,
  input  wire logic        op_done,
  input  wire logic        err_valid,
  input  wire err_kind_e   err_kind,
  input  wire logic        out_msg_waiting,
  input  wire logic        err_pop,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             srq,
  output logic [7:0]       status_byte,
  output logic signed [15:0] err_head,
  output logic             err_empty
);
  localparam int PW = $clog2(QUEUE_DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(QUEUE_DEPTH);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] evt_reg, evt_next, een_reg, een_next, sre_reg, sre_next;
  logic       mav_reg, mav_next, rsp_valid_reg, rsp_valid_next, srq_reg, srq_next;
  logic [7:0] rsp_reg, rsp_next, stb_reg, stb_next;
  logic signed [15:0] q_reg [QUEUE_DEPTH], q_next [QUEUE_DEPTH];
  logic [PW:0] cnt_reg, cnt_next;
  logic signed [15:0] err_num;
  logic [7:0] err_bits, stb_now;
  logic       esb_now, mss_now, do_clear, do_read;
  logic       empty_reg, empty_next;
  // ----------------------------------------------------------------
  // Error numbering and grouping
  // ----------------------------------------------------------------
  always_comb begin
    err_bits = 8'h00;
    case (err_kind)
      EKIND_CMD_GENERIC: err_num = `ERR_CMD_GENERIC; // [RULE12]
      EKIND_CMD_SYNTAX:  err_num = `ERR_CMD_SYNTAX;
      EKIND_CMD_PARAM:   err_num = `ERR_CMD_PARAM;
      EKIND_EXEC_RANGE:  err_num = `ERR_EXEC_RANGE;
      EKIND_QUERY:       err_num = `ERR_QUERY_GENERIC;
      default:           err_num = `ERR_QUEUE_OVERFLOW;
    endcase
    if (err_valid) begin
      case (err_kind)
        EKIND_CMD_GENERIC, EKIND_CMD_SYNTAX, EKIND_CMD_PARAM:
          err_bits[`EVT_CMD_ERR_BIT] = 1'b1; // [RULE4]
        EKIND_EXEC_RANGE: err_bits[`EVT_EXEC_ERR_BIT] = 1'b1;
        EKIND_QUERY:      err_bits[`EVT_QUERY_ERR_BIT] = 1'b1;
        default:          err_bits[`EVT_DEVICE_ERR_BIT] = 1'b1;
      endcase
      // A pop in the same cycle frees a slot, so no overflow is flagged then.
      if (cnt_reg == DEPTH_C && !err_pop) begin
        err_bits[`EVT_DEVICE_ERR_BIT] = 1'b1; // [RULE11]
      end
    end
    if (op_done) begin
      err_bits[`EVT_OP_DONE_BIT] = 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    do_clear = req.valid && req.cmd == CMD_CLEAR;
    do_read  = req.valid && req.cmd == CMD_RD_EVT;
    esb_now  = |(evt_reg & een_reg & `EVT_USED_MASK); // [RULE2] [RULE5]
    stb_now  = 8'h00; // [RULE8]
    stb_now[`STB_MSG_AVAIL_BIT] = mav_reg;
    stb_now[`STB_EVT_SUM_BIT]   = esb_now;
    mss_now  = |(stb_now & sre_reg & `STB_USED_MASK); // [RULE9] [RULE15]
    stb_now[`STB_MASTER_BIT] = mss_now;
    evt_next = evt_reg;
    if (do_clear || do_read) begin
      evt_next = 8'h00; // [RULE1] [RULE13]
    end
    // Events that arrive with a read or clear survive it, so none is lost.
    evt_next = (evt_next | err_bits) & `EVT_USED_MASK; // [RULE17]
    een_next = een_reg;
    sre_next = sre_reg;
    if (req.valid && req.cmd == CMD_WR_EEN) een_next = req.data; // [RULE16]
    if (req.valid && req.cmd == CMD_WR_SRE) sre_next = req.data;
    mav_next = out_msg_waiting && !do_clear; // [RULE7] [RULE14]
    rsp_valid_next = 1'b0;
    rsp_next = rsp_reg;
    if (req.valid) begin
      rsp_valid_next = 1'b1;
      case (req.cmd)
        CMD_RD_EVT: rsp_next = evt_reg;
        CMD_RD_EEN: rsp_next = een_reg;
        CMD_RD_STB: rsp_next = stb_now; // [RULE6]
        CMD_RD_SRE: rsp_next = sre_reg;
        default: begin
          rsp_valid_next = 1'b0;
          rsp_next = rsp_reg;
        end
      endcase
    end
    stb_next = stb_now;
    srq_next = mss_now && (sre_reg != 8'h00); // [RULE10]
    q_next   = q_reg;
    cnt_next = cnt_reg;
    if (err_pop && cnt_reg != '0) begin
      for (int i = 0; i < QUEUE_DEPTH - 1; i++) q_next[i] = q_reg[i+1];
      cnt_next = cnt_reg - 1'b1;
    end
    if (err_valid) begin
      if (cnt_next < DEPTH_C) begin
        q_next[cnt_next[PW-1:0]] = err_num;
        cnt_next = cnt_next + 1'b1;
      end else begin
        q_next[QUEUE_DEPTH-1] = `ERR_QUEUE_OVERFLOW; // [RULE11]
      end
    end
    if (do_clear) cnt_next = '0; // [RULE13]
    empty_next = (cnt_next == '0);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_reg       <= `EVT_RESET_VALUE; // [RULE3]
      een_reg       <= 8'h00;
      sre_reg       <= 8'h00;
      mav_reg       <= 1'b0; // [RULE7]
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= 8'h00;
      stb_reg       <= 8'h00;
      srq_reg       <= 1'b0;
      cnt_reg       <= '0;
      empty_reg     <= 1'b1;
      for (int i = 0; i < QUEUE_DEPTH; i++) q_reg[i] <= 16'sh0000;
    end else begin
      evt_reg       <= evt_next;
      een_reg       <= een_next;
      sre_reg       <= sre_next;
      mav_reg       <= mav_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg       <= rsp_next;
      stb_reg       <= stb_next;
      srq_reg       <= srq_next;
      cnt_reg       <= cnt_next;
      empty_reg     <= empty_next;
      q_reg         <= q_next;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid   = rsp_valid_reg;
  assign rsp_data    = rsp_reg;
  assign srq         = srq_reg;
  assign status_byte = stb_reg;
  assign err_head    = q_reg[0];
  assign err_empty   = empty_reg;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_EVT_READ_CLEARS: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
    do_read && !err_valid && !op_done |=> evt_reg == 8'h00 && rsp_data == $past(evt_reg))
    else $error("event status not cleared by read");
  AST_ERR_GROUP: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
    err_valid && err_kind == EKIND_EXEC_RANGE |=> evt_reg[`EVT_EXEC_ERR_BIT])
    else $error("execution error bit not set");
  AST_ESB: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
    status_byte[`STB_EVT_SUM_BIT] == $past(|(evt_reg & een_reg)))
    else $error("event summary bit wrong");
  AST_STB_READ: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
    req.valid && req.cmd == CMD_RD_STB |=> evt_reg == ($past(evt_reg) | $past(err_bits)))
    else $error("status byte read changed event status");
  AST_MAV_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
    do_clear |=> ##1 !status_byte[`STB_MSG_AVAIL_BIT])
    else $error("message available survived clear");
  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
    (status_byte & 8'h8F) == 8'h00)
    else $error("unused status byte bits set");
  AST_NO_SRQ: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
    sre_reg == 8'h00 |=> !srq)
    else $error("service request with zero enable");
  AST_ENABLE_READBACK: assert property (@(posedge clk) disable iff (!resetn) // [RULE16]
    req.valid && req.cmd == CMD_WR_SRE ##1 req.valid && req.cmd == CMD_RD_SRE
      |=> rsp_data == $past(req.data, 2))
    else $error("service enable readback mismatch");
  AST_LATCH: assert property (@(posedge clk) disable iff (!resetn) // [RULE17]
    evt_reg[`EVT_CMD_ERR_BIT] && !do_read && !do_clear |=> evt_reg[`EVT_CMD_ERR_BIT])
    else $error("event bit lost without read");
  AST_MSS: assert property (@(posedge clk) disable iff (!resetn) // [RULE9] [RULE15]
    status_byte[`STB_MASTER_BIT] == |(status_byte[5:4] & $past(sre_reg[5:4])))
    else $error("master summary bit wrong");
  AST_OVERFLOW: assert property (@(posedge clk) disable iff (!resetn) // [RULE11]
    err_valid && !err_pop && !do_clear && cnt_reg == DEPTH_C
      |=> q_reg[QUEUE_DEPTH-1] == `ERR_QUEUE_OVERFLOW && evt_reg[`EVT_DEVICE_ERR_BIT])
    else $error("queue overflow not recorded");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
    do_clear && !err_valid && !op_done |=> evt_reg == 8'h00 && err_empty)
    else $error("clear status left state behind");
  AST_MAV_FOLLOW: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
    !do_clear |=> mav_reg == $past(out_msg_waiting))
    else $error("message available does not follow output buffer");
endmodule : status_report
`default_nettype wire

// ==== verilog/status_report_defines.svh ====
// Constants for the status reporting block.
`ifndef STATUS_REPORT_DEFINES_SVH
`define STATUS_REPORT_DEFINES_SVH
`define EVT_OP_DONE_BIT    3'd0
`define EVT_QUERY_ERR_BIT  3'd2
`define EVT_DEVICE_ERR_BIT 3'd3
`define EVT_EXEC_ERR_BIT   3'd4
`define EVT_CMD_ERR_BIT    3'd5
`define EVT_POWER_ON_BIT   3'd7
`define STB_MSG_AVAIL_BIT  3'd4
`define STB_EVT_SUM_BIT    3'd5
`define STB_MASTER_BIT     3'd6
`define EVT_USED_MASK      8'hBD
`define STB_USED_MASK      8'h30
`define EVT_RESET_VALUE    8'h80
`define ERR_QUEUE_OVERFLOW 16'shFEA2
`define ERR_GROUP_CMD      16'sd1
`define ERR_GROUP_EXEC     16'sd2
`define ERR_GROUP_DEV      16'sd3
`define ERR_GROUP_QUERY    16'sd4
`define ERR_CMD_GENERIC    16'shFF9C
`define ERR_CMD_SYNTAX     16'shFF9A
`define ERR_CMD_PARAM      16'shFF94
`define ERR_EXEC_RANGE     16'shFF22
`define ERR_QUERY_GENERIC  16'shFE70
`endif

// ==== verilog/status_report_pkg.sv ====
// Types for the status reporting block.
`default_nettype none
package status_report_pkg;
  typedef enum logic [2:0] {
    CMD_NONE    = 3'b000,
    CMD_RD_EVT  = 3'b001,
    CMD_WR_EEN  = 3'b010,
    CMD_RD_EEN  = 3'b011,
    CMD_RD_STB  = 3'b100,
    CMD_WR_SRE  = 3'b101,
    CMD_RD_SRE  = 3'b110,
    CMD_CLEAR   = 3'b111
  } host_cmd_e;
  typedef enum logic [2:0] {
    EKIND_CMD_GENERIC = 3'b000,
    EKIND_CMD_SYNTAX  = 3'b001,
    EKIND_CMD_PARAM   = 3'b010,
    EKIND_EXEC_RANGE  = 3'b011,
    EKIND_QUERY       = 3'b100,
    EKIND_DEVICE      = 3'b101
  } err_kind_e;
  typedef struct packed {
    logic      valid;
    host_cmd_e cmd;
    logic [7:0] data;
  } host_req_s;
endpackage : status_report_pkg
`default_nettype wire
